// ==== rtl/power_supervisor_sequencer.sv ====
// Power supply supervisor and turn-on/turn-off sequencer.
// Assumes comparator flags from pins, an AHB-Lite master, a 25 MHz clock.
//
// Overview of operation
// - Remote on low: 26 ms, then soft start
// - Remote on high: outputs off after 35 ms
// - Rail under/over voltage: power good, outputs off now
// - Latch or non-latch protection chosen by configuration
// - Latched off until remote on recycled
// - Sample line-low flag when under voltage evaluated
// - Under voltage with line low: hiccup restart
// - Fast over power ends PWM cycle immediately
// - Slow over power flag from external weighted comparator
// - Slow over power beyond 7 ms: lock off, except during the off delay
// - PWM duty never above 93 percent
// - Power good drops at once on remote off
// - Line low past filter time drops power good
`timescale 1ns/100ps
module power_supervisor_sequencer
    import supervisor_pkg::*;
#(
    parameter int unsigned TICK_DIV  = TICK_CYCLES,
    parameter int unsigned HICCUP_T  = HICCUP_MS,
    parameter int unsigned ON_T      = ON_DELAY_MS,
    parameter int unsigned OFF_T     = OFF_DELAY_MS
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Host pins
    input  wire logic        remote_on_n,
    output logic             power_good_out,
    // Comparator flags
    input  wire logic        rail_undervolt_fault,
    input  wire logic        rail_overvolt_fault,
    input  wire logic        ac_line_low,
    input  wire logic        overpower_sense,
    input  wire logic        overpower_slow,
    // Supply drive
    output drive_t           drive,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Interrupt
    output logic             irq
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (TICK_DIV < 2 || TICK_DIV > 65535 || HICCUP_T > 65535 ||
        ON_T > 65535 || OFF_T > 65535)
    begin : g_bad
        $error("power_supervisor_sequencer: unsupported parameter");
    end

    // ==========================================================
    // Input synchronisation
    // ==========================================================
    logic [5:0] pins_lvl;
    faults_t    flt;
    logic       on_req;

    pin_sync #(.WIDTH(6)) u_sync
    (
        .clk       (clk),
        .reset     (reset),
        .pin_in    ({~remote_on_n, rail_undervolt_fault, rail_overvolt_fault,
                     ac_line_low, overpower_sense, overpower_slow}),
        .level_out (pins_lvl)
    );

    assign on_req = pins_lvl[5];
    assign flt    = faults_t'(pins_lvl[4:0]);

    // ==========================================================
    // Millisecond tick
    // ==========================================================
    logic [15:0] div_r;
    logic        tick;

    assign tick = (div_r == 16'(TICK_DIV - 1));

    always_ff @(posedge clk)
    begin
        if (reset || tick)
            div_r <= 16'h0000;
        else
            div_r <= div_r + 16'h0001;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    logic             latch_mode_r;
    logic [EV_W-1:0]  irq_st_r;
    logic [EV_W-1:0]  irq_msk_r;
    logic [6:0]       duty_r;
    logic [EV_W-1:0]  events;

    // ==========================================================
    // Fault qualification
    // ==========================================================
    logic [15:0] slow_cnt_r;
    logic [15:0] line_cnt_r;
    logic        slow_trip;
    logic        line_warn;
    logic        rail_fault;

    function automatic logic [15:0] ms_count(input logic active,
                                             input logic [15:0] cnt);
        ms_count = !active ? 16'h0000 :
                   (tick && cnt != 16'hFFFF) ? cnt + 16'h0001 : cnt;
    endfunction

    assign rail_fault = flt.uv | flt.ov;
    assign slow_trip  = (slow_cnt_r > 16'(SLOW_OPP_MS));
    assign line_warn  = (line_cnt_r > 16'(LINE_FILT_MS));

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            slow_cnt_r <= 16'h0000;
            line_cnt_r <= 16'h0000;
        end
        else
        begin
            slow_cnt_r <= ms_count(flt.opp_slow, slow_cnt_r);
            line_cnt_r <= ms_count(flt.line_low, line_cnt_r);
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic [15:0] tmr_r;
    logic [15:0] tmr_nxt;
    logic        hiccup_go;

    // Line-low sampled with every under-voltage evaluation
    assign hiccup_go = flt.uv & flt.line_low;

    always_comb
    begin
        state_nxt = state_r;
        tmr_nxt   = tick ? tmr_r + 16'h0001 : tmr_r;
        case (state_r)
            ST_OFF:
            begin
                tmr_nxt = 16'h0000;
                if (on_req)
                    state_nxt = ST_ON_WAIT;
            end
            ST_ON_WAIT:
            begin
                if (!on_req)
                    state_nxt = ST_OFF;
                else if (tmr_r > 16'(ON_T))
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                tmr_nxt = 16'h0000;
                if (hiccup_go)
                    state_nxt = ST_HICCUP;
                else if (rail_fault || slow_trip)
                    state_nxt = latch_mode_r || slow_trip ? ST_LATCHED
                                                          : ST_OFF;
                else if (!on_req)
                    state_nxt = ST_OFF_WAIT;
            end
            ST_OFF_WAIT:
            begin
                if (rail_fault)
                    state_nxt = latch_mode_r ? ST_LATCHED : ST_OFF;
                else if (on_req)
                    state_nxt = ST_RUN;
                else if (tmr_r > 16'(OFF_T))
                    state_nxt = ST_OFF;
            end
            ST_LATCHED:
            begin
                tmr_nxt = 16'h0000;
                if (!on_req)
                    state_nxt = ST_OFF;
            end
            ST_HICCUP:
            begin
                if (!on_req)
                    state_nxt = ST_OFF;
                else if (tmr_r > 16'(HICCUP_T))
                    state_nxt = ST_ON_WAIT;
            end
            default:
                state_nxt = ST_OFF;
        endcase
        if (state_nxt != state_r)
            tmr_nxt = 16'h0000;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= ST_OFF;
            tmr_r   <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
        end
    end

    // ==========================================================
    // PWM and outputs
    // ==========================================================
    logic [6:0] pwm_cnt_r;
    logic       pwm_on;
    logic       outputs_on;
    logic       seq_on;
    logic       pg_nxt;
    logic       cycle_kill_r;
    logic [6:0] duty_lim;

    assign seq_on     = state_r == ST_RUN || state_r == ST_OFF_WAIT;
    assign outputs_on = seq_on && !rail_fault;
    assign duty_lim   = duty_r > 7'(PWM_MAX_ON) ? 7'(PWM_MAX_ON)
                                                : duty_r;
    assign pwm_on     = outputs_on && pwm_cnt_r < duty_lim &&
                        !flt.opp_fast && !cycle_kill_r;
    assign pg_nxt     = state_r == ST_RUN && on_req && !rail_fault &&
                        !line_warn;

    always_ff @(posedge clk)
    begin
        if (reset || pwm_cnt_r == 7'(PWM_PERIOD - 1))
            pwm_cnt_r <= 7'h00;
        else
            pwm_cnt_r <= pwm_cnt_r + 7'h01;
    end

    // Fast over power holds the rest of the current cycle off
    always_ff @(posedge clk)
    begin
        if (reset || pwm_cnt_r == 7'(PWM_PERIOD - 1))
            cycle_kill_r <= 1'b0;
        else if (flt.opp_fast)
            cycle_kill_r <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            drive          <= '0;
            power_good_out <= 1'b0;
        end
        else
        begin
            drive.soft_start_en <= outputs_on;
            drive.main_out_en   <= outputs_on;
            drive.pwm_kill      <= flt.opp_fast;
            drive.pwm_drive     <= pwm_on;
            power_good_out      <= pg_nxt;
        end
    end

    // ==========================================================
    // Events and interrupt
    // ==========================================================
    logic pg_prev_r;

    always_ff @(posedge clk)
    begin
        if (reset)
            pg_prev_r <= 1'b0;
        else
            pg_prev_r <= pg_nxt;
    end

    assign events[EV_UV]     = seq_on & flt.uv;
    assign events[EV_OV]     = seq_on & flt.ov;
    assign events[EV_HICCUP] = state_r == ST_RUN && hiccup_go;
    assign events[EV_OPP]    = (state_r == ST_RUN && slow_trip) |
                               (outputs_on & flt.opp_fast);
    assign events[EV_LINE]   = line_warn & ~pg_prev_r & pg_nxt ? 1'b0
                                                             : line_warn;
    assign events[EV_PGOOD]  = pg_prev_r ^ pg_nxt;
    assign irq               = |(irq_st_r & irq_msk_r);

    // ==========================================================
    // AHB-Lite slave
    // ==========================================================
    logic       ap_valid;
    logic       dp_wr_r;
    logic       dp_rd_r;
    logic [7:0] dp_addr_r;
    logic       hit_ctrl;
    logic       hit_st;
    logic       hit_msk;
    logic       hit_duty;
    logic       hit_state;
    logic [31:0] rd_nxt;

    assign ap_valid  = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hit_ctrl  = dp_addr_r == ADDR_CTRL;
    assign hit_state = dp_addr_r == ADDR_STATE;
    assign hit_st    = dp_addr_r == ADDR_IRQ_ST;
    assign hit_msk   = dp_addr_r == ADDR_IRQ_MSK;
    assign hit_duty  = dp_addr_r == ADDR_DUTY;

    assign rd_nxt = (haddr[7:0] == ADDR_CTRL)    ? {31'h0, latch_mode_r} :
                    (haddr[7:0] == ADDR_STATE)   ?
                        {24'h0, power_good_out, 1'b0, on_req,
                         flt.line_low, 1'b0, state_r} :
                    (haddr[7:0] == ADDR_IRQ_ST)  ? {26'h0, irq_st_r} :
                    (haddr[7:0] == ADDR_IRQ_MSK) ? {26'h0, irq_msk_r} :
                    (haddr[7:0] == ADDR_DUTY)    ? {25'h0, duty_r} :
                    32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dp_wr_r   <= 1'b0;
            dp_rd_r   <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            dp_wr_r   <= ap_valid && hwrite;
            dp_rd_r   <= ap_valid && !hwrite;
            dp_addr_r <= haddr[7:0];
            if (ap_valid && !hwrite)
                hrdata <= rd_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            latch_mode_r <= CTRL_RST[0];
            irq_msk_r    <= IRQ_MSK_RST;
            duty_r       <= DUTY_RST;
            irq_st_r     <= '0;
        end
        else
        begin
            if (dp_wr_r && hit_ctrl)
                latch_mode_r <= hwdata[CTRL_LATCH_BIT];
            if (dp_wr_r && hit_msk)
                irq_msk_r <= hwdata[EV_W-1:0];
            if (dp_wr_r && hit_duty)
                duty_r <= hwdata[6:0];
            // Set wins over write-one-to-clear
            irq_st_r <= (irq_st_r & ~((dp_wr_r && hit_st) ? hwdata[EV_W-1:0]
                                                          : '0)) | events;
        end
    end

endmodule

// ==== rtl/supervisor_pkg.sv ====
// Shared constants and carrier types for the power supervisor.
// Assumes a 25 MHz system clock; comparator results arrive unsynchronised.
package supervisor_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned ON_DELAY_MS     = 26;
    localparam int unsigned OFF_DELAY_MS    = 35;
    localparam int unsigned HICCUP_MS       = 3000;
    localparam int unsigned SLOW_OPP_MS     = 7;
    localparam int unsigned LINE_FILT_MS    = 4;
    localparam int unsigned PWM_PERIOD      = 100;
    localparam int unsigned PWM_MAX_PCT     = 93;
    localparam int unsigned PWM_MAX_ON      = PWM_PERIOD * PWM_MAX_PCT / 100;

    // ==========================================================
    // AHB-Lite register map
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATE   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
    localparam logic [7:0] ADDR_DUTY    = 8'h10;

    localparam int unsigned CTRL_LATCH_BIT = 0;
    localparam logic [0:0]  CTRL_RST       = 1'h1;
    localparam logic [5:0]  IRQ_MSK_RST    = 6'h00;
    localparam logic [6:0]  DUTY_RST       = 7'h32;

    // Event bits of the interrupt status
    localparam int unsigned EV_UV     = 0;
    localparam int unsigned EV_OV     = 1;
    localparam int unsigned EV_HICCUP = 2;
    localparam int unsigned EV_OPP    = 3;
    localparam int unsigned EV_LINE   = 4;
    localparam int unsigned EV_PGOOD  = 5;
    localparam int unsigned EV_W      = 6;

    typedef enum logic [2:0]
    {
        ST_OFF,
        ST_ON_WAIT,
        ST_RUN,
        ST_OFF_WAIT,
        ST_LATCHED,
        ST_HICCUP
    } seq_state_t;

    // Synchronised comparator flags
    typedef struct packed
    {
        logic uv;
        logic ov;
        logic line_low;
        logic opp_fast;
        logic opp_slow;
    } faults_t;

    // Supply control outputs
    typedef struct packed
    {
        logic soft_start_en;
        logic main_out_en;
        logic pwm_kill;
        logic pwm_drive;
    } drive_t;

endpackage

// ==== rtl/pin_sync.sv ====
// Three-stage synchroniser for a group of asynchronous pins.
// Assumes pins may change at any time relative to clk.
`timescale 1ns/100ps
module pin_sync
    import supervisor_pkg::*;
#(
    parameter int unsigned WIDTH = 6
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Pins and settled levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_nxt;

    // Change accepted once stages two and three agree
    assign level_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_out);

    always_ff @(posedge clk)
    begin
        s1_r      <= pin_in;
        s2_r      <= s1_r;
        s3_r      <= s2_r;
        if (reset)
            level_out <= '0;
        else
            level_out <= level_nxt;
    end

endmodule

// ==== testbench/supervisor_asserts.sv ====
// Pin-level checks on the power supervisor.
// Assumes pins move only on clock edges; bound to the top module.
`timescale 1ns/100ps
module supervisor_asserts
    import supervisor_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic   clk,
    input wire logic   reset,
    // Pins
    input wire logic   remote_on_n,
    input wire logic   power_good_out,
    input wire logic   rail_undervolt_fault,
    input wire logic   rail_overvolt_fault,
    input wire logic   ac_line_low,
    input wire logic   overpower_sense,
    input wire logic   overpower_slow,
    input wire drive_t drive
);
    // ==========================================================
    // Run-length counters
    // ==========================================================
    localparam int unsigned LINE_LIM = 7 * TICK_DIV + 8;
    localparam int unsigned SLOW_LIM = 10 * TICK_DIV + 8;
    localparam int unsigned ON_LIM   = ON_DELAY_MS * TICK_DIV;
    logic [31:0] low_cnt_r;
    logic [15:0] hi_cnt_r;
    logic [15:0] line_cnt_r;
    logic [15:0] slow_cnt_r;

    always_ff @(posedge clk)
    begin
        hi_cnt_r   <= (drive.pwm_drive && !reset) ? hi_cnt_r + 16'h1 : 16'h0;
        line_cnt_r <= (ac_line_low && !reset) ? line_cnt_r + 16'h1 : 16'h0;
        slow_cnt_r <= (overpower_slow && !reset) ? slow_cnt_r + 16'h1 : 16'h0;
        low_cnt_r  <= (!remote_on_n && !reset) ? low_cnt_r + 32'h1 : 32'h0;
    end

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_uv_cuts_out: assert property (
        $rose(rail_undervolt_fault) |-> ##[1:7]
        (!drive.main_out_en && !power_good_out))
        else $error("output on after under voltage");
    a_ov_cuts_out: assert property (
        $rose(rail_overvolt_fault) |-> ##[1:7]
        (!drive.main_out_en && !power_good_out))
        else $error("output on after over voltage");
    a_off_drops_pg: assert property (
        $rose(remote_on_n) |-> ##[1:7] !power_good_out)
        else $error("power good held after remote off");
    a_no_early_start: assert property (
        $fell(remote_on_n) && !drive.soft_start_en |=>
        !drive.soft_start_en [*8])
        else $error("soft start without delay");
    a_on_delay_min: assert property (
        $rose(drive.soft_start_en) |-> low_cnt_r >= ON_LIM)
        else $error("soft start before on delay");
    a_fast_opp_kill: assert property (
        overpower_sense [*5] |=> !drive.pwm_drive)
        else $error("pwm drive during fast over power");
    a_duty_max: assert property (
        hi_cnt_r <= PWM_MAX_ON)
        else $error("pwm on time too long");
    a_line_warn_pg: assert property (
        line_cnt_r == LINE_LIM |-> !power_good_out)
        else $error("power good held with line low");
    a_slow_opp_off: assert property (
        slow_cnt_r == SLOW_LIM |-> !drive.main_out_en)
        else $error("output on after long slow over power");
endmodule

bind power_supervisor_sequencer supervisor_asserts #(.TICK_DIV(TICK_DIV)) i_chk
(
    .clk(clk), .reset(reset), .remote_on_n(remote_on_n),
    .power_good_out(power_good_out), .drive(drive),
    .rail_undervolt_fault(rail_undervolt_fault),
    .rail_overvolt_fault(rail_overvolt_fault), .ac_line_low(ac_line_low),
    .overpower_sense(overpower_sense), .overpower_slow(overpower_slow)
);

// ==== testbench/host_model.sv ====
// Host board: drives the remote on request pin.
// Assumes the bench raises want_on to ask for main power.
`timescale 1ns/100ps
module host_model
(
    // Clock
    input  wire logic clk,
    // Request and pin
    input  wire logic want_on,
    output logic      remote_on_n = 1'h1
);
    // Pulled high when idle; recycling goes high then low
    always @(posedge clk)
        remote_on_n <= !want_on;
endmodule

// ==== testbench/power_supervisor_sequencer_bench.sv ====
// Self-checking bench for the power supervisor.
// Assumes a host model on the remote pin and a 10-clock tick.
`timescale 1ns/100ps
module power_supervisor_sequencer_bench
    import supervisor_pkg::*;
;
    localparam int TD = 10;
    localparam int ON = ON_DELAY_MS;
    logic        clk = 1'h0;
    logic        reset = 1'h1;
    logic        want_on = 1'h0;
    logic        uv = 1'h0, ov = 1'h0, ac = 1'h0, opf = 1'h0, ops = 1'h0;
    logic        hsel = 1'h0, hwrite = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        remote_on_n, power_good_out, hready, hreadyout, hresp, irq;
    drive_t      drive;
    int          n_mismatch = 0, total_checks = 0, n;

    always #20 clk = ~clk;
    assign hready = hreadyout;

    host_model i_host (.clk(clk), .want_on(want_on), .remote_on_n(remote_on_n));

    power_supervisor_sequencer #(.TICK_DIV(TD), .HICCUP_T(5)) i_dut
    (
        .clk(clk), .reset(reset), .remote_on_n(remote_on_n),
        .power_good_out(power_good_out), .rail_undervolt_fault(uv),
        .rail_overvolt_fault(ov), .ac_line_low(ac), .overpower_sense(opf),
        .overpower_slow(ops), .drive(drive), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input int v, input int lo, input int hi);
        total_checks++;
        if (v < lo || v > hi)
        begin
            n_mismatch++;
            $display("BAD %0t delay %0d not in %0d..%0d", $time, v, lo, hi);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'h1)
            @(posedge clk);
        htrans <= 2'h0;
        hsel   <= 1'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'h1)
            @(posedge clk);
        rd = hrdata;
        chk(hresp, 1'h0);
    endtask

    task automatic wait_main(input logic lvl);
        n = 0;
        while (drive.main_out_en !== lvl && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs;
        bus(1'h0, ADDR_CTRL, 32'h0);
        chk(rd, {31'h0, CTRL_RST});
        bus(1'h0, ADDR_IRQ_MSK, 32'h0);
        chk(rd, {26'h0, IRQ_MSK_RST});
        bus(1'h0, ADDR_DUTY, 32'h0);
        chk(rd, {25'h0, DUTY_RST});
        bus(1'h1, ADDR_DUTY, 32'hFF);
        bus(1'h0, ADDR_DUTY, 32'h0);
        chk(rd, 32'h0000_007F);
        bus(1'h0, 8'h40, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_on_off;
        want_on <= 1'h1;
        wait_main(1'h1);
        chk_in(n, ON * TD, (ON + 1) * TD + 8);
        chk(drive.soft_start_en, 1'h1);
        repeat (2) @(posedge clk);
        chk(power_good_out, 1'h1);
        want_on <= 1'h0;
        repeat (7) @(posedge clk);
        chk(power_good_out, 1'h0);
        chk(drive.main_out_en, 1'h1);
        wait_main(1'h0);
        chk_in(n + 7, OFF_DELAY_MS * TD, (OFF_DELAY_MS + 1) * TD + 8);
    endtask

    task automatic t_nonlatch;
        bus(1'h1, ADDR_CTRL, 32'h0);
        want_on <= 1'h1;
        wait_main(1'h1);
        ov <= 1'h1;
        repeat (8) @(posedge clk);
        chk(drive.main_out_en, 1'h0);
        chk(power_good_out, 1'h0);
        ov <= 1'h0;
        wait_main(1'h1);
        chk_in(n, ON * TD, (ON + 1) * TD + 8);
        bus(1'h1, ADDR_CTRL, 32'h1);
    endtask

    task automatic t_latch;
        bus(1'h1, ADDR_IRQ_ST, 32'h3F);
        uv <= 1'h1;
        repeat (8) @(posedge clk);
        uv <= 1'h0;
        bus(1'h0, ADDR_STATE, 32'h0);
        chk(rd[2:0], 3'h4);
        repeat (100) @(posedge clk);
        chk(drive.main_out_en, 1'h0);
        chk(irq, 1'h0);
        bus(1'h1, ADDR_IRQ_MSK, 32'h1);
        @(posedge clk);
        chk(irq, 1'h1);
        bus(1'h1, ADDR_IRQ_ST, 32'h1);
        @(posedge clk);
        chk(irq, 1'h0);
        bus(1'h1, ADDR_IRQ_MSK, 32'h0);
        want_on <= 1'h0;
        repeat (20) @(posedge clk);
        want_on <= 1'h1;
        wait_main(1'h1);
        chk_in(n, ON * TD, (ON + 1) * TD + 8);
    endtask

    task automatic t_hiccup;
        ac <= 1'h1;
        repeat (8 * TD) @(posedge clk);
        chk(power_good_out, 1'h0);
        chk(drive.main_out_en, 1'h1);
        uv <= 1'h1;
        repeat (8) @(posedge clk);
        bus(1'h0, ADDR_STATE, 32'h0);
        chk(rd[2:0], 3'h5);
        chk(rd[4], 1'h1);
        uv <= 1'h0;
        ac <= 1'h0;
        wait_main(1'h1);
        chk_in(n, (ON + 5) * TD - 20, (ON + 7) * TD + 8);
    endtask

    task automatic t_opp;
        opf <= 1'h1;
        repeat (20) @(posedge clk);
        chk(drive.pwm_drive, 1'h0);
        chk(drive.pwm_kill, 1'h1);
        opf <= 1'h0;
        ops <= 1'h1;
        repeat (5 * TD) @(posedge clk);
        ops <= 1'h0;
        repeat (20) @(posedge clk);
        chk(drive.main_out_en, 1'h1);
        ops <= 1'h1;
        repeat (15 * TD) @(posedge clk);
        ops <= 1'h0;
        chk(drive.main_out_en, 1'h0);
        bus(1'h0, ADDR_STATE, 32'h0);
        chk(rd[2:0], 3'h4);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        t_regs();
        t_on_off();
        t_nonlatch();
        t_latch();
        t_hiccup();
        t_opp();
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
